// File: logic/jis_regs.vh
// register offsets, field positions and reset values for jog selection
`ifndef JIS_REGS_VH
`define JIS_REGS_VH
// interface byte offsets
`define JIS_SEL_REQ_OFS      8'h05
`define JIS_MOTION_STAT_OFS  8'h40
`define JIS_ACTIVE_SEL_OFS   8'h41
// request / active selection bit positions
`define JIS_BIT_SINGLE       0
`define JIS_BIT_TENS         1
`define JIS_BIT_HUNDREDS     2
`define JIS_BIT_THOUSANDS    3
`define JIS_BIT_TEN_THOUS    4
`define JIS_BIT_VARIABLE     5
`define JIS_BIT_CONTINUOUS   6
// motion status bit positions
`define JIS_BIT_CMD_PLUS     7
`define JIS_BIT_CMD_MINUS    6
`define JIS_BIT_REQ_PLUS     5
`define JIS_BIT_REQ_MINUS    4
`define JIS_HW_LSB           0
`define JIS_HW_MSB           2
// reset values
`define JIS_STAT_RESET       8'h00
`define JIS_SEL_RESET        7'h00
`endif

// File: logic/jis_sel_decode.v
// selection decode: conflict check and increment size lookup
`include "jis_regs.vh"
module jis_sel_decode #(
  parameter W      = 24,
  parameter SIZE_1 = 24'h000001,
  parameter SIZE_2 = 24'h00000a,
  parameter SIZE_3 = 24'h000064,
  parameter SIZE_4 = 24'h0003e8,
  parameter SIZE_5 = 24'h002710
) (
  // request side
  input  wire [6:0]   req_bits,
  input  wire [W-1:0] var_size,
  // decoded side
  output wire [6:0]   active_sel,
  output reg  [W-1:0] step_size
);
  // more than one bit set when clearing the lowest one leaves any
  wire [6:0] lowest_cleared = req_bits & (req_bits - 7'h01);
  wire       conflict       = |lowest_cleared;

  // conflicting request activates nothing
  assign active_sel = conflict ? `JIS_SEL_RESET : req_bits;

  //////////////////////////////////////////////////////////////////////
  // size lookup from the fixed table or the variable setting
  always @* begin
    step_size = {W{1'b0}};
    if (active_sel[`JIS_BIT_SINGLE]) begin
      step_size = SIZE_1;
    end else if (active_sel[`JIS_BIT_TENS]) begin
      step_size = SIZE_2;
    end else if (active_sel[`JIS_BIT_HUNDREDS]) begin
      step_size = SIZE_3;
    end else if (active_sel[`JIS_BIT_THOUSANDS]) begin
      step_size = SIZE_4;
    end else if (active_sel[`JIS_BIT_TEN_THOUS]) begin
      step_size = SIZE_5;
    end else if (active_sel[`JIS_BIT_VARIABLE]) begin
      step_size = var_size;
    end
  end
endmodule

// File: logic/jis_top.v
// per-axis jog increment selection and increment traverse engine
//
// Functional notes
// - bits 0-5 pick increment per key/detent
// - fixed sizes from table, variable from setting
// - several selection bits set: no function
// - selection dropped or switched aborts increment
// - bit 6 alone selects continuous jogging
// - active selection reported one bit each
// - held-key increment pauses and resumes
// - second rising edge cancels latched increment
// - both keys together stop all motion
`include "jis_regs.vh"
module jis_top #(
  parameter W      = 24,
  parameter SIZE_1 = 24'h000001,
  parameter SIZE_2 = 24'h00000a,
  parameter SIZE_3 = 24'h000064,
  parameter SIZE_4 = 24'h0003e8,
  parameter SIZE_5 = 24'h002710
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         rst_n,
  // controller request byte and setting
  input  wire [7:0]   jog_selection_request,
  input  wire [W-1:0] variable_increment_setting,
  // operating state
  input  wire         manual_mode,
  input  wire         key_latch_mode,
  input  wire         handwheel_fine_offset,
  // traverse keys and handwheel
  input  wire         traverse_plus,
  input  wire         traverse_minus,
  input  wire [2:0]   handwheel_assigned,
  input  wire         handwheel_detent,
  input  wire         handwheel_dir_plus,
  // status bytes
  output reg  [7:0]   axis_motion_status,
  output reg  [7:0]   active_jog_selection,
  // motion drive
  output reg          move_step,
  output reg          move_dir_plus
);
  //////////////////////////////////////////////////////////////////////
  // reset release through two flops
  // entry stays asynchronous, exit lines up with the clock
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_ok_n = rst_sync_reg;

  //////////////////////////////////////////////////////////////////////
  // selection decode
  // a conflicting request decodes to all zero, so everything below
  // sees it exactly like an empty request
  wire [6:0]   sel;         // conflict-free selection
  wire [W-1:0] inc_size;    // size for current selection
  jis_sel_decode #(
    .W      (W),
    .SIZE_1 (SIZE_1),
    .SIZE_2 (SIZE_2),
    .SIZE_3 (SIZE_3),
    .SIZE_4 (SIZE_4),
    .SIZE_5 (SIZE_5)
  ) u_dec (
    .req_bits   (jog_selection_request[6:0]),
    .var_size   (variable_increment_setting),
    .active_sel (sel),
    .step_size  (inc_size)
  );

  //////////////////////////////////////////////////////////////////////
  // engine state
  reg  [6:0]   sel_prev_reg;   // selection seen last cycle
  reg          plus_d_reg;     // key history for edges
  reg          minus_d_reg;
  reg          run_reg;        // increment or continuous jog active
  reg          dir_reg;        // 1 = plus
  reg          hw_reg;         // increment started by handwheel
  reg  [W-1:0] remain_reg;     // units left in increment
  reg          run_next;
  reg          dir_next;
  reg          hw_next;
  reg  [W-1:0] remain_next;
  reg          moving;         // one unit moved this cycle

  // selection class of the decoded request
  wire inc_sel    = |sel[`JIS_BIT_VARIABLE:`JIS_BIT_SINGLE];
  wire cont_sel   = sel[`JIS_BIT_CONTINUOUS];
  wire sel_change = (sel != sel_prev_reg);
  // rising edges against last cycle's key levels
  wire both_keys  = traverse_plus & traverse_minus;
  wire rise_plus  = traverse_plus & ~plus_d_reg;
  wire rise_minus = traverse_minus & ~minus_d_reg;
  wire rise_any   = (rise_plus ^ rise_minus) & ~both_keys;
  wire rise_same  = dir_reg ? rise_plus : rise_minus;
  wire key_same   = dir_reg ? traverse_plus : traverse_minus;
  // handwheel increments also valid outside manual with fine offset
  wire hw_allowed = manual_mode | handwheel_fine_offset;
  // single keys only act in manual traverse mode; outside it only a
  // handwheel increment under fine offset may start or carry on
  wire key_lost   = ~manual_mode &
                    (~handwheel_fine_offset | cont_sel | (run_reg & ~hw_reg));
  // any abort source empties the increment in the same cycle
  wire abort      = sel_change | both_keys | key_lost;

  //////////////////////////////////////////////////////////////////////
  // next-state of the traverse engine
  always @* begin
    run_next    = run_reg;
    dir_next    = dir_reg;
    hw_next     = hw_reg;
    remain_next = remain_reg;
    moving      = 1'b0;
    // abort first, then increment, continuous, and none
    if (abort) begin
      // selection change, both keys or loss of key mode kill motion at once
      run_next    = 1'b0;
      hw_next     = 1'b0;
      remain_next = {W{1'b0}};
    end else if (inc_sel) begin
      if (run_reg) begin
        if (key_latch_mode && !hw_reg && rise_same) begin
          // second edge cancels, increment left unfinished
          run_next    = 1'b0;
          remain_next = {W{1'b0}};
        end else if (key_latch_mode || hw_reg || key_same) begin
          // latched or handwheel increment runs on; otherwise the held key gates motion, pause without it
          moving      = 1'b1;
          remain_next = remain_reg - {{(W-1){1'b0}}, 1'b1};
          if (remain_reg == {{(W-1){1'b0}}, 1'b1}) begin
            run_next = 1'b0;
            hw_next  = 1'b0;
          end
        end
      end else if (manual_mode && rise_any) begin
        // key edge loads a fresh increment
        run_next    = (inc_size != {W{1'b0}});
        dir_next    = rise_plus;
        hw_next     = 1'b0;
        remain_next = inc_size;
      end else if (hw_allowed && handwheel_detent) begin
        // one detent moves one increment
        run_next    = (inc_size != {W{1'b0}});
        dir_next    = handwheel_dir_plus;
        hw_next     = 1'b1;
        remain_next = inc_size;
      end
    end else if (cont_sel) begin
      remain_next = {W{1'b0}};
      hw_next     = 1'b0;
      if (key_latch_mode) begin
        // latched: first edge starts, next same edge stops
        if (run_reg && rise_same) begin
          run_next = 1'b0;
        end else if (!run_reg && rise_any) begin
          run_next = 1'b1;
          dir_next = rise_plus;
        end
        moving = run_reg;
      end else begin
        // jog: move only while a key is held
        run_next = traverse_plus ^ traverse_minus;
        dir_next = traverse_plus;
        moving   = traverse_plus ^ traverse_minus;
      end
    end else begin
      // nothing selected: no motion at all
      run_next    = 1'b0;
      hw_next     = 1'b0;
      remain_next = {W{1'b0}};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state and output registers
  always @(posedge ref_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      sel_prev_reg         <= `JIS_SEL_RESET;
      plus_d_reg           <= 1'b0;
      minus_d_reg          <= 1'b0;
      run_reg              <= 1'b0;
      dir_reg              <= 1'b0;
      hw_reg               <= 1'b0;
      remain_reg           <= {W{1'b0}};
      move_step            <= 1'b0;
      move_dir_plus        <= 1'b0;
      axis_motion_status   <= `JIS_STAT_RESET;
      active_jog_selection <= `JIS_STAT_RESET;
    end else begin
      // history for change and edge detection
      sel_prev_reg  <= sel;
      plus_d_reg    <= traverse_plus;
      minus_d_reg   <= traverse_minus;
      // traverse engine state
      run_reg       <= run_next;
      dir_reg       <= dir_next;
      hw_reg        <= hw_next;
      remain_reg    <= remain_next;
      move_step     <= moving;
      // direction follows the next state so it never lags the step
      move_dir_plus <= dir_next;
      // one status bit per active option, zero when none
      active_jog_selection <= {1'b0, sel};
      // motion command, traverse request, handwheel assignment
      axis_motion_status <= {moving & dir_next,
                             moving & ~dir_next,
                             run_next & dir_next,
                             run_next & ~dir_next,
                             1'b0,
                             handwheel_assigned};
    end
  end
endmodule

// File: testbench/jis_properties.sv
// checker for selection, abort and key rules at the jog block ports
module jis_properties (
  input logic       ref_clk,
  input logic       rst_n,
  input logic [7:0] jog_selection_request,
  input logic       manual_mode,
  input logic       key_latch_mode,
  input logic       traverse_plus,
  input logic       traverse_minus,
  input logic [7:0] axis_motion_status,
  input logic [7:0] active_jog_selection,
  input logic       move_step,
  input logic       move_dir_plus
);
  logic [1:0] up_reg; // edges since release, saturating
  logic [6:0] sel;    // request without the ignored top bit
  logic       ok;     // internal two-flop reset has let go
  assign sel = jog_selection_request[6:0];
  assign ok = up_reg == 2'h3;
  // skip the edges while the internal reset copy still holds
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) up_reg <= 2'h0;
    else if (!ok) up_reg <= up_reg + 2'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rep; ok && $onehot($past(sel)) |->
    active_jog_selection == {1'b0, $past(sel)}; endproperty
  a_rep: assert property (p_rep) else $error("bad selection");
  property p_cnf; ok && $countones($past(sel)) > 1 |->
    active_jog_selection == 8'h00; endproperty
  a_cnf: assert property (p_cnf) else $error("conflict shown");
  property p_non; ok && $past(sel) == 7'h00 && $past(sel, 2) == 7'h00
    |-> !move_step && active_jog_selection == 8'h00; endproperty
  a_non: assert property (p_non) else $error("idle moved");
  property p_two; ok && $past(traverse_plus && traverse_minus)
    |-> !move_step; endproperty
  a_two: assert property (p_two) else $error("both keys moved");
  property p_con; ok && $past(sel, 2) == 7'h40 && $past(sel) == 7'h40
    && $past(manual_mode && !key_latch_mode && traverse_plus &&
    !traverse_minus) |-> move_step && move_dir_plus; endproperty
  a_con: assert property (p_con) else $error("no jog step");
  property p_pau; ok && $past(!key_latch_mode && !traverse_plus &&
    !traverse_minus) |-> !move_step; endproperty
  a_pau: assert property (p_pau) else $error("moved keyless");
  property p_abt; ok && $past(sel) != $past(sel, 2) |->
    axis_motion_status[5:4] == 2'h0; endproperty
  a_abt: assert property (p_abt) else $error("no abort");
  property p_dir; move_step |-> axis_motion_status[7:6] ==
    {move_dir_plus, !move_dir_plus}; endproperty
  a_dir: assert property (p_dir) else $error("bad motion bits");
  c_inc: cover property (move_step && active_jog_selection == 8'h02);
  c_cnf: cover property (ok && $countones(sel) > 1);
  c_con: cover property (move_step && active_jog_selection == 8'h40);
endmodule

bind jis_top jis_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .jog_selection_request(jog_selection_request),
  .manual_mode(manual_mode), .key_latch_mode(key_latch_mode),
  .traverse_plus(traverse_plus), .traverse_minus(traverse_minus),
  .axis_motion_status(axis_motion_status),
  .active_jog_selection(active_jog_selection),
  .move_step(move_step), .move_dir_plus(move_dir_plus));

// File: testbench/jis_plc_model.sv
// model of the controller writing the request byte and traverse keys
module jis_plc_model (
  input  logic       ref_clk,
  input  logic [7:0] cmd_req,
  input  logic [1:0] cmd_keys,
  output logic [7:0] jog_selection_request,
  output logic       traverse_plus,
  output logic       traverse_minus
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    jog_selection_request = 8'h00;
    {traverse_plus, traverse_minus} = 2'h0;
  end
  // apply each command a short step after the edge that took it
  always @(posedge ref_clk) begin
    jog_selection_request <= #1 cmd_req;
    {traverse_plus, traverse_minus} <= #1 cmd_keys;
  end
endmodule

// File: testbench/test_jog_increment_select.sv
// self-checking bench for the jog increment selection block
module test_jog_increment_select;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] r; logic m; logic [1:0] k; logic [15:0] n; logic [7:0] a;
  } jis_row_t;
  logic ref_clk = 1'h0, rst_n = 1'h0, manual_mode = 1'h1;
  logic key_latch_mode = 1'h0, tp, tm, move_step, move_dir_plus;
  logic [7:0] cmd_req = 8'h00, req, status, active;
  logic [1:0] cmd_keys = 2'h0;
  logic [2:0] hw_asg = 3'h5;
  int err_count = 0, checked = 0;
  logic [15:0] cnt = 16'h0;
  jis_row_t rows [12] = '{'{8'h01,1'h1,2'h2,16'h1,8'h01},
    '{8'h02,1'h1,2'h2,16'ha,8'h02}, '{8'h04,1'h1,2'h2,16'h13,8'h04},
    '{8'h08,1'h1,2'h2,16'h13,8'h08}, '{8'h10,1'h1,2'h2,16'h13,8'h10},
    '{8'h20,1'h1,2'h2,16'h7,8'h20}, '{8'h40,1'h1,2'h2,16'h14,8'h40},
    '{8'h40,1'h0,2'h2,16'h0,8'h40}, '{8'h03,1'h1,2'h2,16'h0,8'h00},
    '{8'h00,1'h1,2'h2,16'h0,8'h00}, '{8'h82,1'h1,2'h1,16'ha,8'h02},
    '{8'h02,1'h1,2'h3,16'h0,8'h02}};
  jis_plc_model plc (.ref_clk(ref_clk), .cmd_req(cmd_req),
    .cmd_keys(cmd_keys), .jog_selection_request(req),
    .traverse_plus(tp), .traverse_minus(tm));
  jis_top dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .jog_selection_request(req), .variable_increment_setting(24'h000007),
    .manual_mode(manual_mode), .key_latch_mode(key_latch_mode),
    .handwheel_fine_offset(1'h0), .traverse_plus(tp), .traverse_minus(tm),
    .handwheel_assigned(hw_asg), .handwheel_detent(1'h0),
    .handwheel_dir_plus(1'h0), .axis_motion_status(status),
    .active_jog_selection(active), .move_step(move_step),
    .move_dir_plus(move_dir_plus));
  always #2 ref_clk = ~ref_clk;
  // count units moved
  always @(posedge ref_clk) if (move_step) cnt++;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // hold a key for n cycles, then let the motion settle
  task automatic press(input logic [1:0] k, input int n);
    cmd_keys <= #1 k;
    wait_cyc(n);
    cmd_keys <= #1 2'h0;
    wait_cyc(6);
  endtask
  task automatic give_verdict;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog well past the expected run of about 585 cycles
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
  initial begin
    wait_cyc(2);
    chk("reset status", 16'h0, {status, active}); // outputs cleared
    rst_n <= #1 1'h1;
    wait_cyc(4);
    chk("handwheel echo", 16'h5, status[2:0]);
    $display("reset test done");
    foreach (rows[i]) begin
      manual_mode <= #1 rows[i].m;
      cmd_req <= #1 rows[i].r;
      wait_cyc(4);
      cnt <= #1 16'h0;
      press(rows[i].k, 20);
      chk("active", rows[i].a, active);
      chk("steps", rows[i].n, cnt);
      $display("row %0d done", i);
    end
    // pause, resume, then a switch drops the remainder
    cmd_req <= #1 8'h04;
    wait_cyc(4);
    cnt <= #1 16'h0;
    press(2'h2, 10);
    chk("paused request", 16'h2, status[5:4]);
    press(2'h2, 10);
    chk("resumed steps", 16'h13, cnt);
    cmd_req <= #1 8'h02;
    wait_cyc(4);
    cnt <= #1 16'h0;
    press(2'h2, 20);
    chk("after switch", 16'ha, cnt);
    $display("abort test done");
    // minus increment keeps its direction while paused
    cmd_req <= #1 8'h08;
    wait_cyc(4);
    press(2'h1, 3);
    chk("minus request", 16'h1, status[5:4]);
    chk("minus dir", 16'h0, move_dir_plus);
    $display("minus test done");
    // second rising edge cancels a latched increment
    key_latch_mode <= #1 1'h1;
    cmd_req <= #1 8'h04;
    wait_cyc(4);
    cnt <= #1 16'h0;
    press(2'h2, 2);
    press(2'h2, 2);
    wait_cyc(120);
    chk("cancelled", 16'h1, cnt < 16'h64);
    chk("request clear", 16'h0, status[5]);
    $display("cancel test done");
    give_verdict;
  end
endmodule
